// ===== bspc_pkg.sv
// package for the battery switch-over power control block
// assumes an apb slave on a 10 mhz clock
package bspc_pkg;
    localparam logic [2:0] BSPC_SEL_RESET = 3'h0;
    localparam logic [2:0] BSPC_SEL_STD_ALL = 3'h0;
    localparam logic [2:0] BSPC_SEL_STD_PF = 3'h1;
    localparam logic [2:0] BSPC_SEL_STD_NONE = 3'h2;
    localparam logic [2:0] BSPC_SEL_DIR_ALL = 3'h3;
    localparam logic [2:0] BSPC_SEL_DIR_PF = 3'h4;
    localparam logic [2:0] BSPC_SEL_DIR_NONE = 3'h5;
    localparam logic [2:0] BSPC_SEL_OFF_PF = 3'h6;
    localparam logic [2:0] BSPC_SEL_OFF_NONE = 3'h7;
    // register byte addresses
    localparam logic [11:0] BSPC_CTRL_ADDR = 12'h000;
    localparam logic [11:0] BSPC_STAT_ADDR = 12'h004;
    // control field positions
    localparam int BSPC_CTRL_SEL_LSB = 0;
    localparam int BSPC_CTRL_IE_BIT = 4;
    localparam int BSPC_CTRL_TSE_BIT = 5;
    // status field positions
    localparam int BSPC_STAT_BSF_BIT = 0;
    localparam int BSPC_STAT_BLF_BIT = 1;
    localparam int BSPC_STAT_BAK_BIT = 2;
    localparam int BSPC_STAT_LOWEN_BIT = 3;
    localparam int BSPC_STAT_PFEN_BIT = 4;

    typedef enum logic [1:0] {
        BSPC_MODE_STD,
        BSPC_MODE_DIRECT,
        BSPC_MODE_OFF
    } bspc_mode_t;

    typedef struct packed {
        logic main_below_backup;
        logic main_below_thresh;
        logic battery_low;
    } bspc_cmp_t;

    typedef enum {
        BSPC_ST_MAIN,
        BSPC_ST_BACKUP
    } bspc_state_t;

    typedef struct packed {
        bspc_cmp_t sync1;
        bspc_cmp_t sync2;
        logic [2:0] power_mgmt_select;
        logic battery_switch_irq_enable;
        logic switch_timestamp_enable;
        logic battery_switch_flag;
        logic battery_low_flag;
        logic on_backup;
        logic timestamp_pulse;
        logic [31:0] prdata;
    } bspc_regs_t;
endpackage : bspc_pkg

// ===== bspc_top.sv
// battery switch-over power control with apb register access
// assumes comparator inputs are asynchronous and host pads are resolved outside
// Behaviour
// - codes 000, 001, 010 select standard mode; detection enables as listed; reset 000.
// - codes 011-101 select direct mode with listed detection enables.
// - codes 110 and 111 disable switch-over; low detection off.
// - switch-over disabled always forces battery-low detection off.
// - standard mode fails when main below backup and threshold.
// - direct mode fails when main below backup only.
// - switching to backup sets the battery switch flag in the same cycle.
// - interrupt raised only with the switch interrupt enable set.
// - timestamp capture triggered on switch when timestamp enable set.
// - switch flag stays set until software clears it by write or switch-over is disabled.
// - interrupt stays pending until the switch flag or the switch interrupt enable is cleared.
// - on backup, host interface inputs are ignored.
// - on backup, host interface outputs are high impedance.
// - with switch-over disabled the switch flag reads zero.
// - battery-low flag not host clearable; clears when battery recovers.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
module bspc_top
    import bspc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous comparator results
    input wire bspc_pkg::bspc_cmp_t cmp_async,
    // power state outputs
    output logic battery_switch_irq,
    output logic timestamp_capture,
    output logic backed_supply_output,
    output logic host_out_enable,
    output logic battery_low_detect_en,
    output logic power_fail_detect_en
);
    import bspc_pkg::*;

    bspc_regs_t r_reg;
    bspc_regs_t r_next;
    bspc_mode_t mode;
    logic low_en;
    logic pf_en;
    logic fail;
    logic access;
    logic wr_ctrl;
    logic wr_stat;
    logic rd_hit;
    logic [31:0] rd_val;

    always_comb begin
        mode = BSPC_MODE_STD;
        low_en = 1'b0;
        pf_en = 1'b0;
        case (r_reg.power_mgmt_select)
            BSPC_SEL_STD_ALL: begin
                low_en = 1'b1;
                pf_en = 1'b1;
            end
            BSPC_SEL_STD_PF: begin
                pf_en = 1'b1;
            end
            BSPC_SEL_STD_NONE: begin
                mode = BSPC_MODE_STD;
            end
            BSPC_SEL_DIR_ALL: begin
                mode = BSPC_MODE_DIRECT;
                low_en = 1'b1;
                pf_en = 1'b1;
            end
            BSPC_SEL_DIR_PF: begin
                mode = BSPC_MODE_DIRECT;
                pf_en = 1'b1;
            end
            BSPC_SEL_DIR_NONE: begin
                mode = BSPC_MODE_DIRECT;
            end
            BSPC_SEL_OFF_PF: begin
                mode = BSPC_MODE_OFF;
                pf_en = 1'b1;
            end
            default: begin
                mode = BSPC_MODE_OFF;
            end
        endcase
        if (mode == BSPC_MODE_OFF) begin
            low_en = 1'b0;
        end
    end

    always_comb begin
        case (mode)
            BSPC_MODE_STD: fail = r_reg.sync2.main_below_backup & r_reg.sync2.main_below_thresh;
            BSPC_MODE_DIRECT: fail = r_reg.sync2.main_below_backup;
            default: fail = 1'b0;
        endcase
    end

    assign access = psel & penable & ~r_reg.on_backup;
    assign wr_ctrl = access & pwrite & (paddr == BSPC_CTRL_ADDR);
    assign wr_stat = access & pwrite & (paddr == BSPC_STAT_ADDR);
    assign rd_hit = (paddr == BSPC_CTRL_ADDR) | (paddr == BSPC_STAT_ADDR);

    always_comb begin
        rd_val = 32'h0;
        if (paddr == BSPC_CTRL_ADDR) begin
            rd_val[BSPC_CTRL_SEL_LSB +: 3] = r_reg.power_mgmt_select;
            rd_val[BSPC_CTRL_IE_BIT] = r_reg.battery_switch_irq_enable;
            rd_val[BSPC_CTRL_TSE_BIT] = r_reg.switch_timestamp_enable;
        end else if (paddr == BSPC_STAT_ADDR) begin
            rd_val[BSPC_STAT_BSF_BIT] = r_reg.battery_switch_flag & (mode != BSPC_MODE_OFF);
            rd_val[BSPC_STAT_BLF_BIT] = r_reg.battery_low_flag;
            rd_val[BSPC_STAT_BAK_BIT] = r_reg.on_backup;
            rd_val[BSPC_STAT_LOWEN_BIT] = low_en;
            rd_val[BSPC_STAT_PFEN_BIT] = pf_en;
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.sync1 = cmp_async;
        r_next.sync2 = r_reg.sync1;
        r_next.on_backup = fail;
        r_next.timestamp_pulse = 1'b0;
        if (psel & ~penable & ~pwrite & ~r_reg.on_backup) begin
            r_next.prdata = rd_val;
        end
        if (wr_ctrl) begin
            r_next.power_mgmt_select = pwdata[BSPC_CTRL_SEL_LSB +: 3];
            r_next.battery_switch_irq_enable = pwdata[BSPC_CTRL_IE_BIT];
            r_next.switch_timestamp_enable = pwdata[BSPC_CTRL_TSE_BIT];
        end
        // cleared by write of one, and below while switch-over is disabled
        if (wr_stat & pwdata[BSPC_STAT_BSF_BIT]) begin
            r_next.battery_switch_flag = 1'b0;
        end
        // flag set on switch, set wins
        if (fail & ~r_reg.on_backup) begin
            r_next.battery_switch_flag = 1'b1;
            r_next.timestamp_pulse = r_reg.switch_timestamp_enable;
        end
        if (mode == BSPC_MODE_OFF) begin
            r_next.battery_switch_flag = 1'b0;
        end
        r_next.battery_low_flag = low_en & r_reg.sync2.battery_low;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (~rd_hit | r_reg.on_backup);
    assign battery_switch_irq = r_reg.battery_switch_flag & r_reg.battery_switch_irq_enable;
    assign timestamp_capture = r_reg.timestamp_pulse;
    assign backed_supply_output = r_reg.on_backup;
    assign host_out_enable = ~r_reg.on_backup;
    assign battery_low_detect_en = low_en;
    assign power_fail_detect_en = pf_en;

    std_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == BSPC_MODE_STD && r_reg.sync2.main_below_backup && r_reg.sync2.main_below_thresh
         && $stable(r_reg.power_mgmt_select)) |=> r_reg.on_backup)
        else $error("standard mode failure missed");
    dir_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == BSPC_MODE_DIRECT && r_reg.sync2.main_below_backup) |=> r_reg.on_backup)
        else $error("direct mode failure missed");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(r_reg.on_backup) && mode != BSPC_MODE_OFF |-> r_reg.battery_switch_flag)
        else $error("switch flag not set");
    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.battery_switch_flag && !wr_stat && mode != BSPC_MODE_OFF |=> r_reg.battery_switch_flag)
        else $error("switch flag dropped");
    low_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == BSPC_MODE_OFF |-> !low_en ##1 !r_reg.battery_low_flag)
        else $error("low detection active while disabled");
    flag_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == BSPC_MODE_OFF |=> !r_reg.battery_switch_flag)
        else $error("switch flag set while disabled");
    ts_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(r_reg.on_backup) && $past(r_reg.switch_timestamp_enable) |-> timestamp_capture ##1 !timestamp_capture)
        else $error("timestamp capture not pulsed");
    bus_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.on_backup && psel && penable |=> $stable(r_reg.power_mgmt_select))
        else $error("write taken on backup");
    irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(r_reg.on_backup) && r_reg.battery_switch_irq_enable && mode != BSPC_MODE_OFF |-> battery_switch_irq)
        else $error("irq not raised on switch");
    sync_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.sync2 == $past(cmp_async, 2))
        else $error("synchroniser latency wrong");
    sync_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.sync1 == $past(cmp_async))
        else $error("first stage latency wrong");
    sel_std_a: assert property (@(posedge clk) disable iff (!rst_n)
        (r_reg.power_mgmt_select <= BSPC_SEL_STD_NONE) |-> mode == BSPC_MODE_STD)
        else $error("standard code not standard mode");
    en_all_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_STD_ALL |-> low_en && pf_en)
        else $error("code 000 enables wrong");
    en_pf_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_STD_PF |-> !low_en && pf_en)
        else $error("code 001 enables wrong");
    en_none_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_STD_NONE |-> !low_en && !pf_en)
        else $error("code 010 enables wrong");
    sel_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        (r_reg.power_mgmt_select >= BSPC_SEL_DIR_ALL && r_reg.power_mgmt_select <= BSPC_SEL_DIR_NONE)
        |-> mode == BSPC_MODE_DIRECT)
        else $error("direct code not direct mode");
    dir_all_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_DIR_ALL |-> low_en && pf_en)
        else $error("code 011 enables wrong");
    dir_pf_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_DIR_PF |-> !low_en && pf_en)
        else $error("code 100 enables wrong");
    dir_none_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_DIR_NONE |-> !low_en && !pf_en)
        else $error("code 101 enables wrong");
    sel_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (r_reg.power_mgmt_select >= BSPC_SEL_OFF_PF) |-> mode == BSPC_MODE_OFF)
        else $error("disable code not disabled");
    off_pf_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_OFF_PF |-> !low_en && pf_en)
        else $error("code 110 enables wrong");
    off_none_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.power_mgmt_select == BSPC_SEL_OFF_NONE |-> !low_en && !pf_en)
        else $error("code 111 enables wrong");
    low_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == BSPC_MODE_OFF |-> !battery_low_detect_en)
        else $error("low detect enable while disabled");
    std_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == BSPC_MODE_STD && !r_reg.sync2.main_below_thresh |=> !r_reg.on_backup)
        else $error("standard switch above threshold");
    dir_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode == BSPC_MODE_DIRECT && !r_reg.sync2.main_below_backup |=> !r_reg.on_backup)
        else $error("direct switch without failure");
    flag_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(r_reg.battery_switch_flag) |-> $rose(r_reg.on_backup))
        else $error("switch flag set without switch");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !r_reg.battery_switch_irq_enable |-> !battery_switch_irq)
        else $error("irq raised while disabled");
    ts_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        timestamp_capture |-> $rose(r_reg.on_backup))
        else $error("timestamp capture without switch");
    ts_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(r_reg.on_backup) && !$past(r_reg.switch_timestamp_enable) |-> !timestamp_capture)
        else $error("timestamp capture while disabled");
    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_stat && pwdata[BSPC_STAT_BSF_BIT] |=> !r_reg.battery_switch_flag || $rose(r_reg.on_backup))
        else $error("switch flag not cleared");
    irq_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        battery_switch_irq && !wr_stat && !wr_ctrl && mode != BSPC_MODE_OFF |=> battery_switch_irq)
        else $error("irq dropped while pending");
    irq_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        battery_switch_irq && wr_stat && pwdata[BSPC_STAT_BSF_BIT] |=> !battery_switch_irq || $rose(r_reg.on_backup))
        else $error("irq kept after clear");
    bus_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.on_backup && psel && penable |-> pslverr)
        else $error("no error on backup access");
    bus_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.on_backup && psel && penable
        |=> $stable({r_reg.battery_switch_irq_enable, r_reg.switch_timestamp_enable}))
        else $error("enable written on backup");
    host_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        backed_supply_output |-> !host_out_enable)
        else $error("host outputs driven on backup");
    read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && !penable && !pwrite && paddr == BSPC_STAT_ADDR && mode == BSPC_MODE_OFF && !r_reg.on_backup
        |=> !prdata[BSPC_STAT_BSF_BIT])
        else $error("switch flag read while disabled");
    blf_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        r_reg.battery_low_flag && r_reg.sync2.battery_low && low_en |=> r_reg.battery_low_flag)
        else $error("low flag dropped while low");
    blf_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        !r_reg.sync2.battery_low |=> !r_reg.battery_low_flag)
        else $error("low flag kept after recovery");

    std_switch_c: cover property (@(posedge clk) disable iff (!rst_n)
        mode == BSPC_MODE_STD ##1 $rose(r_reg.on_backup));
    dir_switch_c: cover property (@(posedge clk) disable iff (!rst_n)
        mode == BSPC_MODE_DIRECT ##1 $rose(r_reg.on_backup));
    irq_clear_c: cover property (@(posedge clk) disable iff (!rst_n)
        battery_switch_irq ##1 !battery_switch_irq);
    low_flag_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(r_reg.battery_low_flag));
    ts_pulse_c: cover property (@(posedge clk) disable iff (!rst_n) timestamp_capture);
endmodule : bspc_top

// ===== bspc_supply_model.sv
// supply comparator model standing outside the switch-over block
// assumes supply levels in millivolts, driven by the bench
`timescale 1ns/1ns
module bspc_supply_model
    import bspc_pkg::*;
#(
    parameter int LOW_MV = 2500
)
(
    // supply levels
    input wire logic [15:0] main_mv,
    input wire logic [15:0] backup_mv,
    input wire logic [15:0] thresh_mv,
    // comparator results
    output bspc_pkg::bspc_cmp_t cmp
);
    // plain level compares, no hysteresis, outputs change at any time
    assign cmp = '{main_mv < backup_mv, main_mv < thresh_mv, backup_mv < LOW_MV};
endmodule : bspc_supply_model

// ===== bspc_bench.sv
// self-checking bench for the switch-over block
// assumes apb answers in the access cycle with read data standing in that cycle
`timescale 1ns/1ns
module bspc_bench;
    import bspc_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic irq, tsc, bak, hoe, low_en, pf_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] main_mv, backup_mv;
    logic [1:0] exp_en [8];
    bspc_cmp_t cmp;
    int error_cnt, n_checks;
    int ts_cnt = 0;

    bspc_supply_model SUP (.main_mv(main_mv), .backup_mv(backup_mv), .thresh_mv(16'h9c4), .cmp(cmp));
    bspc_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_async(cmp), .battery_switch_irq(irq), .timestamp_capture(tsc),
        .backed_supply_output(bak), .host_out_enable(hoe),
        .battery_low_detect_en(low_en), .power_fail_detect_en(pf_en));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (tsc === 1'h1) ts_cnt <= ts_cnt + 1;

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        err = pslverr;
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
        if (n >= 20) begin
            error_cnt++;
            $display("[ERR] %0t bus timeout", $time);
            close_out();
        end
    endtask : apb

    task automatic sup(input logic [15:0] m, input logic [15:0] b);
        main_mv <= m;
        backup_mv <= b;
    endtask : sup

    task automatic wait_bak(input logic exp);
        int n;
        n = 0;
        while (bak !== exp && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, bak}, {31'h0, exp});
        if (bak !== exp) begin
            close_out();
        end
    endtask : wait_bak

    initial begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        main_mv = 16'hce4;
        backup_mv = 16'hbb8;
        error_cnt = 0;
        n_checks = 0;
        exp_en = '{2'h3, 2'h1, 2'h0, 2'h3, 2'h1, 2'h0, 2'h1, 2'h0};
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        apb(1'h0, BSPC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, BSPC_STAT_ADDR, 32'h0);
        chk(rd, 32'h18);
        for (int i = 0; i < 8; i++) begin
            apb(1'h1, BSPC_CTRL_ADDR, 32'(i));
            chk({30'h0, low_en, pf_en}, {30'h0, exp_en[i]});
        end
        apb(1'h0, 12'h008, 32'h0);
        chk({31'h0, err}, 32'h1);
        // standard mode: below backup alone is no failure
        apb(1'h1, BSPC_CTRL_ADDR, 32'h30);
        sup(16'haf0, 16'hbb8);
        repeat (6) @(posedge clk);
        chk({31'h0, bak}, 32'h0);
        sup(16'h7d0, 16'hbb8);
        repeat (2) @(posedge clk);
        chk({31'h0, bak}, 32'h0);
        wait_bak(1'h1);
        repeat (2) @(posedge clk);
        chk({30'h0, irq, hoe}, 32'h2);
        chk(32'(ts_cnt), 32'h1);
        apb(1'h1, BSPC_CTRL_ADDR, 32'h7);
        chk({31'h0, err}, 32'h1);
        sup(16'hce4, 16'hbb8);
        wait_bak(1'h0);
        apb(1'h0, BSPC_CTRL_ADDR, 32'h0);
        chk(rd, 32'h30);
        apb(1'h0, BSPC_STAT_ADDR, 32'h0);
        chk(rd, 32'h19);
        chk({31'h0, irq}, 32'h1);
        apb(1'h1, BSPC_STAT_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // direct mode, interrupt and timestamp off
        apb(1'h1, BSPC_CTRL_ADDR, 32'h3);
        sup(16'haf0, 16'hbb8);
        wait_bak(1'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        chk(32'(ts_cnt), 32'h1);
        sup(16'hce4, 16'hbb8);
        wait_bak(1'h0);
        apb(1'h1, BSPC_CTRL_ADDR, 32'h13);
        chk({31'h0, irq}, 32'h1);
        apb(1'h1, BSPC_STAT_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // switch-over disabled
        apb(1'h1, BSPC_CTRL_ADDR, 32'h6);
        sup(16'h7d0, 16'hbb8);
        repeat (6) @(posedge clk);
        chk({31'h0, bak}, 32'h0);
        apb(1'h0, BSPC_STAT_ADDR, 32'h0);
        chk(rd, 32'h10);
        // battery low flag
        sup(16'hce4, 16'h7d0);
        repeat (6) @(posedge clk);
        apb(1'h1, BSPC_CTRL_ADDR, 32'h0);
        apb(1'h1, BSPC_STAT_ADDR, 32'h2);
        apb(1'h0, BSPC_STAT_ADDR, 32'h0);
        chk(rd, 32'h1a);
        sup(16'hce4, 16'hbb8);
        repeat (6) @(posedge clk);
        apb(1'h0, BSPC_STAT_ADDR, 32'h0);
        chk(rd, 32'h18);
        close_out();
    end
endmodule : bspc_bench
